// ### rtl/aphp_pkg.sv
// Package for the host-side controller of the asynchronous parallel port.
// Assumes a 100 MHz system clock; the device port itself has no clock.
package aphp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Timing, in ns and in cycles of the 10 ns clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 60;
  localparam int HOLD_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } aphp_state_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } aphp_req_t;

endpackage

// ### rtl/aphp_host.sv
// Host controller that drives the device's asynchronous parallel port.
// Assumes the device answers within the fixed strobe time and that the
// bus style level is steady while the port is in use.
// Notes on behaviour
// RL1 - Thirteen-bit address selects one register
// RL2 - Eight-bit bidirectional data bus, bit 7 top
// RL3 - Strobes count only with chip select low
// RL4 - Device drives data during qualified read
// RL5 - Write data stands around strobe rising edge
// RL6 - Interrupt pin low on unmasked event
// RL7 - Interrupt released after all sources serviced
// RL8 - Sources masked at several device levels
// RL9 - Style select high: data strobe plus direction
// RL10 - Strobe pins change meaning with style
// RL11 - Direction high reads, low writes
// RL12 - Data bus floats except during reads
// RL13 - Device reset restores register defaults
`timescale 1ns/1ps
`default_nettype none

module aphp_host
  import aphp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User request side
  input wire logic req_valid,
  input wire aphp_pkg::aphp_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [aphp_pkg::DATA_W-1:0] rsp_rdata,
  output logic irq_pending,
  // Style and reset control
  input wire logic style_data_strobe,
  input wire logic device_reset_req,
  // Device pins
  output logic [aphp_pkg::ADDR_W-1:0] addr_out,
  input wire logic [aphp_pkg::DATA_W-1:0] data_in,
  output logic [aphp_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic chip_select_n,
  output logic read_or_data_strobe_n,
  output logic write_strobe_or_direction,
  output logic bus_style_select,
  output logic device_reset_n,
  input wire logic irq_out_n
);
  import aphp_pkg::*;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] irq_sync_reg;
  logic [DATA_W-1:0] data_s1_reg, data_s2_reg, data_s3_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_sync_reg <= 3'h7;
      data_s1_reg <= DATA_RESET;
      data_s2_reg <= DATA_RESET;
      data_s3_reg <= DATA_RESET;
    end else begin
      irq_sync_reg <= {irq_sync_reg[1:0], irq_out_n};
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
      data_s3_reg <= data_s2_reg;
    end
  end

  // Interrupt level changes only when stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pending <= 1'b0;
    end else if (irq_sync_reg[1] == irq_sync_reg[2]) begin
      irq_pending <= ~irq_sync_reg[2]; // [RL6] [RL7]
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  aphp_state_t state_reg, state_next;
  logic [3:0] cnt_reg;
  logic write_reg;
  logic style_reg;

  function automatic logic [3:0] cyc(input int n);
    cyc = 4'(n - 1);
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (req_valid && req_ready) state_next = ST_SETUP;
      ST_SETUP: if (cnt_reg == CNT_ZERO) state_next = ST_STROBE;
      ST_STROBE: if (cnt_reg == CNT_ZERO) state_next = ST_HOLD;
      ST_HOLD: if (cnt_reg == CNT_ZERO) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      if (state_reg != state_next) begin
        case (state_next)
          ST_SETUP: cnt_reg <= cyc(SETUP_CYC);
          ST_STROBE: cnt_reg <= cyc(STROBE_CYC);
          ST_HOLD: cnt_reg <= cyc(HOLD_CYC);
          default: cnt_reg <= CNT_ZERO;
        endcase
      end else if (cnt_reg != CNT_ZERO) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  // Style latched per access so pins never change meaning mid-cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_reg <= 1'b0;
      style_reg <= 1'b0;
      bus_style_select <= 1'b0;
      addr_out <= ADDR_RESET;
      data_out <= DATA_RESET;
    end else if (state_reg == ST_IDLE && req_valid && req_ready) begin
      write_reg <= req.write;
      style_reg <= style_data_strobe;
      bus_style_select <= style_data_strobe; // [RL9]
      addr_out <= req.addr; // [RL1]
      data_out <= req.wdata; // [RL2]
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic active_next, strobe_next;
  logic take, write_now, style_now;
  assign active_next = (state_next != ST_IDLE);
  assign strobe_next = (state_next == ST_STROBE);
  assign take = (state_reg == ST_IDLE) && req_valid && req_ready;
  // At the take edge the new access sets the pins, so direction never shows the last access
  assign write_now = take ? req.write : write_reg;
  assign style_now = take ? style_data_strobe : style_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_n <= 1'b1;
      read_or_data_strobe_n <= 1'b1;
      write_strobe_or_direction <= 1'b1;
      data_oe <= 1'b0;
    end else begin
      chip_select_n <= ~active_next; // [RL3]
      // Write data driven from the second setup cycle through strobe and hold only [RL5] [RL12]
      data_oe <= active_next && write_reg && (state_reg != ST_IDLE);
      if (style_now) begin
        read_or_data_strobe_n <= ~strobe_next; // [RL10] [RL11]
        write_strobe_or_direction <= active_next ? ~write_now : 1'b1;
      end else begin
        read_or_data_strobe_n <= ~(strobe_next && !write_now); // [RL10] [RL4]
        write_strobe_or_direction <= ~(strobe_next && write_now);
      end
    end
  end

  // ----------------------------------------------------------------
  // Handshake and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= DATA_RESET;
    end else begin
      req_ready <= (state_next == ST_IDLE) && !(state_reg == ST_IDLE && req_valid && req_ready);
      rsp_valid <= (state_reg == ST_HOLD) && (cnt_reg == CNT_ZERO);
      // Sample at strobe end; synchroniser delay stays inside the strobe
      if (state_reg == ST_STROBE && cnt_reg == CNT_ZERO && !write_reg) begin
        rsp_rdata <= data_s3_reg; // [RL4]
      end
    end
  end

  // Device reset pin follows the request, held low (asserted) during local reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      device_reset_n <= 1'b0;
    end else begin
      device_reset_n <= ~device_reset_req; // [RL13]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_strobe_on;
    !read_or_data_strobe_n || (!style_reg && !write_strobe_or_direction);
  endsequence

  a_strobe_needs_cs: assert property (@(posedge clk) disable iff (!reset_n) // [RL3]
    s_strobe_on |-> !chip_select_n) else $error("strobe active without chip select");
  a_float_on_read: assert property (@(posedge clk) disable iff (!reset_n) // [RL12]
    (!chip_select_n && !write_reg) |-> !data_oe) else $error("data driven during read");
  a_write_data_stable: assert property (@(posedge clk) disable iff (!reset_n) // [RL5]
    ($rose(write_strobe_or_direction) && !style_reg && data_oe) |-> $stable(data_out))
    else $error("write data moved at strobe edge");
  a_write_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RL5]
    ($rose(write_strobe_or_direction) && !style_reg) |-> data_oe && !chip_select_n)
    else $error("write data not held after strobe");
  a_ds_direction: assert property (@(posedge clk) disable iff (!reset_n) // [RL11]
    (style_reg && !read_or_data_strobe_n) |-> (write_strobe_or_direction == !write_reg))
    else $error("direction wrong in data strobe style");
  a_addr_stable: assert property (@(posedge clk) disable iff (!reset_n) // [RL1]
    (!chip_select_n && !$past(chip_select_n)) |-> $stable(addr_out))
    else $error("address moved during access");
  a_style_stable: assert property (@(posedge clk) disable iff (!reset_n) // [RL9]
    (!chip_select_n && !$past(chip_select_n)) |-> $stable(bus_style_select))
    else $error("bus style changed during access");
  a_access_ends: assert property (@(posedge clk) disable iff (!reset_n) // [RL10]
    $fell(chip_select_n) |-> ##[1:20] rsp_valid) else $error("access did not finish");
  a_irq_follow: assert property (@(posedge clk) disable iff (!reset_n) // [RL6]
    (irq_sync_reg[2] == irq_sync_reg[1]) |=> (irq_pending == !$past(irq_sync_reg[2])))
    else $error("interrupt flag not following pin");
  a_dev_reset: assert property (@(posedge clk) disable iff (!reset_n) // [RL13]
    device_reset_req |=> !device_reset_n) else $error("device reset not driven");

endmodule // aphp_host

`default_nettype wire

// ### verif/aphp_dev_model.sv
// Behavioural model of the device behind the parallel host port.
// Assumes the bench resolves the data bus and the interrupt pull-up.
`timescale 1ns/1ps
`default_nettype none

module aphp_dev_model
  import aphp_pkg::*;
#(
  parameter logic [12:0] ACK_ADDR = 13'h1fff
)
(
  // Device pins
  input wire logic [aphp_pkg::ADDR_W-1:0] addr,
  input wire logic [aphp_pkg::DATA_W-1:0] bus,
  input wire logic cs_n,
  input wire logic rds_n,
  input wire logic wsd,
  input wire logic style,
  input wire logic rst_n,
  output logic dev_oe,
  output logic [aphp_pkg::DATA_W-1:0] dev_q,
  output logic irq_drive,
  // Interrupt stimulus
  input wire logic [3:0] src_set,
  input wire logic [3:0] mask
);
  logic [7:0] mem [0:8191];
  logic [3:0] src;
  logic store_pin;
  logic pin_was;
  // Read drive only while qualified; the bench floats the bus otherwise
  assign dev_oe = !cs_n && !rds_n && (!style || wsd);
  assign dev_q = mem[addr];
  assign irq_drive = |(src & ~mask);
  // Data strobe commits in its own style, write strobe in the other
  assign store_pin = style ? rds_n : wsd;
  // One process owns the sources and the memory, so each has a single driver
  always @(negedge rst_n or store_pin or src_set) begin
    if (!rst_n) begin
      foreach (mem[i]) mem[i] = 8'h00;
      src = 4'h0;
    end else begin
      src = src | src_set;
      if (store_pin === 1'b1 && pin_was === 1'b0 && !cs_n && (!style || !wsd)) begin
        // Writing ones to the acknowledge place clears those sources
        if (addr == ACK_ADDR) src = src & ~bus[3:0];
        else mem[addr] = bus;
      end
    end
    pin_was = store_pin;
  end
endmodule // aphp_dev_model

`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the parallel port host controller.
// Assumes the device model of this folder on the far side.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import aphp_pkg::*;
  logic clk = 0, reset_n = 0, req_valid = 0, style = 0, dreset = 0;
  aphp_req_t req = '0;
  logic req_ready, rsp_valid, irq_pending, data_oe, cs_n, rds_n, wsd, bss, dev_rst_n, dev_oe, irq_drive;
  logic [DATA_W-1:0] rsp_rdata, data_out, dev_q, flt = 8'h00;
  logic [ADDR_W-1:0] addr_out;
  logic [3:0] src_set = 4'h0, mask = 4'h0;
  // A floating bus shows a changing pattern, never the last value
  wire logic [DATA_W-1:0] bus = data_oe ? data_out : dev_oe ? dev_q : flt;
  wire logic irq_n = irq_drive ? 1'b0 : 1'b1;
  logic [8:0] expq [$];
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  int fails = 0, n_checks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) flt <= flt + 8'h35;

  aphp_host i_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_pending(irq_pending), .style_data_strobe(style),
    .device_reset_req(dreset), .addr_out(addr_out), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
    .chip_select_n(cs_n), .read_or_data_strobe_n(rds_n), .write_strobe_or_direction(wsd),
    .bus_style_select(bss), .device_reset_n(dev_rst_n), .irq_out_n(irq_n));
  aphp_dev_model i_dev (.addr(addr_out), .bus(bus), .cs_n(cs_n), .rds_n(rds_n), .wsd(wsd), .style(bss),
    .rst_n(dev_rst_n), .dev_oe(dev_oe), .dev_q(dev_q), .irq_drive(irq_drive), .src_set(src_set), .mask(mask));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk) begin : mon
    logic [8:0] e;
    if (data_oe === 1'b1 && dev_oe === 1'b1) check("bus contention", 8'h00, 8'h01);
    if (rsp_valid === 1'b1) begin
      if (expq.size() == 0) check("response count", 8'h00, 8'h01);
      else begin
        e = expq.pop_front();
        if (e[8]) check("read data", e[7:0], rsp_rdata);
      end
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Request stays up between transfers, so back-to-back takes follow
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d};
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) fails++;
    expq.push_back({!w, shadow.exists(a) ? shadow[a] : 8'h00});
    if (w) shadow[a] = d;
    @(posedge clk);
  endtask
  task automatic idle();
    int n;
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 60 && expq.size() > 0; n++) @(negedge clk);
    if (expq.size() > 0) fails++;
  endtask
  task automatic settle_irq(logic exp);
    repeat (6) @(negedge clk);
    check("irq pending", {7'h00, exp}, {7'h00, irq_pending});
  endtask

  initial begin : main
    logic [ADDR_W-1:0] a [4];
    logic [7:0] d [4];
    void'($urandom(85));
    repeat (6) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    for (int s = 0; s < 2; s++) begin
      style = s[0];
      foreach (a[i]) begin
        a[i] = 13'($urandom_range(8190));
        d[i] = 8'($urandom);
        access(1'b1, a[i], d[i]);
      end
      foreach (a[i]) access(1'b0, a[i], 8'h00);
      idle();
      $display("test access style %0d done", s);
    end
    dreset = 1'b1;
    repeat (2) @(negedge clk);
    check("device reset pin", 8'h00, {7'h00, dev_rst_n});
    dreset = 1'b0;
    shadow.delete();
    access(1'b0, a[0], 8'h00);
    idle();
    $display("test device reset done");
    src_set = 4'h5;
    settle_irq(1'b1);
    src_set = 4'h0;
    mask = 4'h5;
    settle_irq(1'b0);
    mask = 4'h0;
    access(1'b1, 13'h1fff, 8'h01);
    idle();
    settle_irq(1'b1);
    access(1'b1, 13'h1fff, 8'h04);
    idle();
    settle_irq(1'b0);
    $display("test interrupt done");
    summarize();
  end
  initial begin : watchdog
    #200us;
    fails++;
    summarize();
  end
endmodule // testbench

`default_nettype wire
